// ---- design/intr_pkg.sv ----
// intr_pkg: constants, register map, carriers and state types shared by the
// interrupt unit and its two helper modules.
// assumes an 8-bit register port and a single system clock domain.
package intr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int TMR_N  = 2;  // timer/event counters with own vectors
    localparam int SLOT_N = 2;  // touch key time slot vectors
    localparam int TKT_N  = 4;  // touch key 16-bit timer sources
    localparam int GRP_N  = 2;  // grouped vectors, two touch timers each
    localparam int VEC_N  = 8;
    localparam int VEC_W  = 3;
    localparam int TB_W   = 13;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_ENABLE    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_SRC_EN    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SRC_FLAGS = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_TB_CTRL   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_TB_CLKSEL = 4'h5;

    // field positions
    localparam int ENA_GLOBAL = 0;
    localparam int ENA_TB     = 1;
    localparam int ENA_SER    = 2;
    localparam int ENA_TMR    = 3;  // two bits
    localparam int ENA_GRP    = 5;  // two bits
    localparam int FLG_TB     = 0;
    localparam int FLG_SER    = 1;
    localparam int FLG_TMR    = 2;  // two bits
    localparam int FLG_GRP    = 4;  // two bits
    localparam int FLG_SLOT   = 6;  // two bits
    localparam int SRC_TKT    = 0;  // four bits
    localparam int SRC_EE     = 4;
    localparam int SRC_SLOT   = 5;  // two bits, enables only
    localparam int TB_SEL_POS = 4;  // two bits
    localparam int CLK_SEL    = 0;

    // time base periods in input clock periods, per select code
    localparam logic [TB_W:0] TB_PERIOD_00 = 14'h0400;
    localparam logic [TB_W:0] TB_PERIOD_01 = 14'h0800;
    localparam logic [TB_W:0] TB_PERIOD_10 = 14'h1000;
    localparam logic [TB_W:0] TB_PERIOD_11 = 14'h2000;

    // vector numbers, lowest number wins
    typedef enum logic [VEC_W-1:0] {
        VEC_SLOT0 = 3'b000,
        VEC_SLOT1 = 3'b001,
        VEC_GRP0  = 3'b010,
        VEC_GRP1  = 3'b011,
        VEC_TMR0  = 3'b100,
        VEC_TMR1  = 3'b101,
        VEC_TB    = 3'b110,
        VEC_SER   = 3'b111
    } vec_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed {
        logic              take;     // vector call issued
        vec_type           vec;
        logic              global_en;
        logic              wake;
    } core_ans_type;

    typedef struct packed {
        logic              global_en;
        logic              tb_en;
        logic              ser_en;
        logic [TMR_N-1:0]  tmr_en;
        logic [GRP_N-1:0]  grp_en;
        logic [TKT_N-1:0]  tkt_en;
        logic              ee_en;
        logic [SLOT_N-1:0] slot_en;
        logic              tb_flag;
        logic              ser_flag;
        logic [TMR_N-1:0]  tmr_flag;
        logic [GRP_N-1:0]  grp_flag;
        logic [SLOT_N-1:0] slot_flag;
        logic [TKT_N-1:0]  tkt_flag;
        logic              ee_flag;
        logic [1:0]        tb_sel;
        logic              tb_clk_sel;
        logic [DATA_W-1:0] rdata;
        core_ans_type      ans;
    } unit_state_type;

    typedef struct packed {
        logic [TB_W-1:0]   count;
        logic              ovf;
    } tb_state_type;

endpackage

// ---- design/timebase_divider.sv ----
// timebase_divider: counts input clock ticks and pulses once per selected
// period of 1024, 2048, 4096 or 8192 ticks.
// assumes tick_in is a synchronous one-cycle enable from the selected source.
`timescale 1ns/10ps
module timebase_divider
(
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    input  wire logic       tick_in,
    input  wire logic [1:0] sel_in,
    output logic            ovf_out
);
    intr_pkg::tb_state_type q;
    intr_pkg::tb_state_type d;
    logic [intr_pkg::TB_W:0] period;

    // period decode from the select field
    always_comb
    begin
        unique case (sel_in)
            2'b00: period = intr_pkg::TB_PERIOD_00;
            2'b01: period = intr_pkg::TB_PERIOD_01;
            2'b10: period = intr_pkg::TB_PERIOD_10;
            2'b11: period = intr_pkg::TB_PERIOD_11;
        endcase
    end

    // wrap on the terminal count; a shorter period picked mid-count wraps at once
    always_comb
    begin
        d     = q;
        d.ovf = 1'b0;
        if (tick_in)
        begin
            if ({1'b0, q.count} >= period - 14'h0001)
            begin
                d.count = '0;
                d.ovf   = 1'b1;                         // [RULE5]
            end
            else
            begin
                d.count = q.count + 13'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            q <= '0;
        else if (ce_in)
            q <= d;
    end

    assign ovf_out = q.ovf;
endmodule

// ---- design/vector_priority.sv ----
// vector_priority: picks the lowest numbered pending vector.
// assumes request bit i belongs to vector number i; purely combinational.
`timescale 1ns/10ps
module vector_priority
(
    input  wire logic [intr_pkg::VEC_N-1:0] req_in,
    output logic                            valid_out,
    output intr_pkg::vec_type               index_out
);
    // first set bit from the low end
    function automatic intr_pkg::vec_type first_set(input logic [intr_pkg::VEC_N-1:0] r);
        intr_pkg::vec_type v;
        v = intr_pkg::VEC_SER;
        for (int i = intr_pkg::VEC_N - 1; i >= 0; i--)
        begin
            if (r[i])
                v = intr_pkg::vec_type'(i[intr_pkg::VEC_W-1:0]);
        end
        return v;
    endfunction

    // fixed order among vectors
    always_comb
    begin
        valid_out = |req_in;
        index_out = first_set(req_in);                  // [RULE21]
    end
endmodule

// ---- design/mcu_interrupt_unit.sv ----
// mcu_interrupt_unit: request flags, enables, grouped requests, time base
// and vector selection for the processor core.
// assumes the core takes a vector on the cycle after take goes high, tells us
// when its stack is full, and pulses a strobe when a return-from-interrupt runs.
// Overview of operation
// [RULE1] two grouped requests are built from touch key timer sources; group 0 also takes eeprom write end
// [RULE2] any enabled contained source event sets its group flag
// [RULE3] enabled group flag with free stack calls the group vector
// [RULE4] group service clears group flag and global enable, not source flags
// [RULE5] time base overflow sets its flag; vector needs global and own enable
// [RULE6] time base counts system clock or the low speed rc clock ticks
// [RULE7] period select bits 5:4 choose 1024 to 8192 ticks; others read zero
// [RULE8] timer overflow sets its flag; service clears it and global enable
// [RULE9] eeprom write end sets its flag; needs its enable and group enable
// [RULE10] software clears the eeprom flag after service
// [RULE11] touch slot counter overflow sets its flag; service clears it
// [RULE12] serial byte done sets its flag; service clears it and global enable
// [RULE13] any flag rising pulses wake regardless of enables
// [RULE14] software pre-sets a flag to stop it waking the device
// [RULE15] flags stay set until serviced or cleared; enables never clear them
// [RULE16] service code saves its own working registers; only pc is pushed
// [RULE17] return-from-interrupt sets global enable; plain return leaves it cleared
// [RULE18] service code avoids nested calls to keep the stack safe
// [RULE19] no vector while global enable is low; flags still record events
// [RULE20] no vector while the stack is full
// [RULE21] simultaneous requests go by fixed vector priority
// [RULE22] a hardware set beats a clear in the same cycle
`timescale 1ns/10ps
module mcu_interrupt_unit
(
    input  wire logic                            core_clk_in,
    input  wire logic                            sys_rst_in,
    input  wire logic                            ce_in,
    input  wire intr_pkg::reg_req_type           reg_req_in,
    output logic [intr_pkg::DATA_W-1:0]          reg_rdata_out,
    input  wire logic                            boundary_in,
    input  wire logic                            stack_full_in,
    input  wire logic                            ret_irq_in,
    output intr_pkg::core_ans_type               core_ans_out,
    input  wire logic                            lirc_tick_in,
    input  wire logic [intr_pkg::TMR_N-1:0]      tmr_ovf_in,
    input  wire logic [intr_pkg::SLOT_N-1:0]     slot_ovf_in,
    input  wire logic [intr_pkg::TKT_N-1:0]      tkt_ovf_in,
    input  wire logic                            ee_done_in,
    input  wire logic                            ser_byte_in
);
    intr_pkg::unit_state_type          q;
    intr_pkg::unit_state_type          d;
    logic                              tb_ovf;
    logic                              tb_tick;
    logic [intr_pkg::VEC_N-1:0]        pend;
    logic                              pick_valid;
    intr_pkg::vec_type                 pick;
    logic [intr_pkg::GRP_N-1:0]        grp_event;
    logic                              wr_en;
    logic                              wr_flags;
    logic                              wr_src;

    // source of the time base input clock
    assign tb_tick = q.tb_clk_sel ? lirc_tick_in : 1'b1; // [RULE6]

    timebase_divider u_tb
    (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .ce_in       (ce_in),
        .tick_in     (tb_tick),
        .sel_in      (q.tb_sel),
        .ovf_out     (tb_ovf)
    );

    // each group collects two touch timers; group 0 also holds eeprom done
    for (genvar g = 0; g < intr_pkg::GRP_N; g++)
    begin : g_grp
        if (g == 0)
        begin : g_ee
            assign grp_event[g] = |(tkt_ovf_in[2*g +: 2] & q.tkt_en[2*g +: 2])
                                | (ee_done_in & q.ee_en);   // [RULE1] [RULE9]
        end
        else
        begin : g_plain
            assign grp_event[g] = |(tkt_ovf_in[2*g +: 2] & q.tkt_en[2*g +: 2]); // [RULE1]
        end
    end

    // pending vectors, bit number equals vector number
    always_comb
    begin
        pend = '0;
        pend[intr_pkg::VEC_SLOT0] = q.slot_flag[0] & q.slot_en[0];   // [RULE11]
        pend[intr_pkg::VEC_SLOT1] = q.slot_flag[1] & q.slot_en[1];   // [RULE11]
        pend[intr_pkg::VEC_GRP0]  = q.grp_flag[0] & q.grp_en[0];     // [RULE3]
        pend[intr_pkg::VEC_GRP1]  = q.grp_flag[1] & q.grp_en[1];     // [RULE3]
        pend[intr_pkg::VEC_TMR0]  = q.tmr_flag[0] & q.tmr_en[0];     // [RULE8]
        pend[intr_pkg::VEC_TMR1]  = q.tmr_flag[1] & q.tmr_en[1];     // [RULE8]
        pend[intr_pkg::VEC_TB]    = q.tb_flag & q.tb_en;             // [RULE5]
        pend[intr_pkg::VEC_SER]   = q.ser_flag & q.ser_en;           // [RULE12]
    end

    vector_priority u_prio
    (
        .req_in    (pend),
        .valid_out (pick_valid),
        .index_out (pick)
    );

    // write decode
    assign wr_en    = reg_req_in.wr & (reg_req_in.addr == intr_pkg::OFS_ENABLE);
    assign wr_flags = reg_req_in.wr & (reg_req_in.addr == intr_pkg::OFS_FLAGS);
    assign wr_src   = reg_req_in.wr & (reg_req_in.addr == intr_pkg::OFS_SRC_FLAGS);

    // next state: software write, then service clear, then hardware sets on top
    always_comb
    begin
        d          = q;
        d.ans.take = 1'b0;
        d.ans.wake = 1'b0;
        d.rdata    = '0;

        // software writes of enables and configuration
        if (wr_en)
        begin
            d.global_en = reg_req_in.wdata[intr_pkg::ENA_GLOBAL];
            d.tb_en     = reg_req_in.wdata[intr_pkg::ENA_TB];
            d.ser_en    = reg_req_in.wdata[intr_pkg::ENA_SER];
            d.tmr_en    = reg_req_in.wdata[intr_pkg::ENA_TMR +: intr_pkg::TMR_N];
            d.grp_en    = reg_req_in.wdata[intr_pkg::ENA_GRP +: intr_pkg::GRP_N];
        end
        if (reg_req_in.wr && reg_req_in.addr == intr_pkg::OFS_SRC_EN)
        begin
            d.tkt_en  = reg_req_in.wdata[intr_pkg::SRC_TKT +: intr_pkg::TKT_N];
            d.ee_en   = reg_req_in.wdata[intr_pkg::SRC_EE];
            d.slot_en = reg_req_in.wdata[intr_pkg::SRC_SLOT +: intr_pkg::SLOT_N];
        end
        if (reg_req_in.wr && reg_req_in.addr == intr_pkg::OFS_TB_CTRL)
            d.tb_sel = reg_req_in.wdata[intr_pkg::TB_SEL_POS +: 2];          // [RULE7]
        if (reg_req_in.wr && reg_req_in.addr == intr_pkg::OFS_TB_CLKSEL)
            d.tb_clk_sel = reg_req_in.wdata[intr_pkg::CLK_SEL];              // [RULE6]

        // software may set or clear flags; setting one ahead of sleep masks its wake
        if (wr_flags)
        begin
            d.tb_flag   = reg_req_in.wdata[intr_pkg::FLG_TB];
            d.ser_flag  = reg_req_in.wdata[intr_pkg::FLG_SER];
            d.tmr_flag  = reg_req_in.wdata[intr_pkg::FLG_TMR +: intr_pkg::TMR_N];
            d.grp_flag  = reg_req_in.wdata[intr_pkg::FLG_GRP +: intr_pkg::GRP_N];
            d.slot_flag = reg_req_in.wdata[intr_pkg::FLG_SLOT +: intr_pkg::SLOT_N];
        end
        if (wr_src)
        begin
            d.tkt_flag = reg_req_in.wdata[intr_pkg::SRC_TKT +: intr_pkg::TKT_N];
            d.ee_flag  = reg_req_in.wdata[intr_pkg::SRC_EE];                  // [RULE10]
        end

        // return from interrupt re-opens the global enable
        if (ret_irq_in)
            d.global_en = 1'b1;                                               // [RULE17]

        // service: only when globally enabled, stack has room and core is ready
        if (q.global_en && pick_valid && !stack_full_in && boundary_in)      // [RULE19] [RULE20]
        begin
            d.ans.take  = 1'b1;
            d.ans.vec   = pick;
            d.global_en = 1'b0;                                               // [RULE4]
            unique case (pick)
                intr_pkg::VEC_SLOT0: d.slot_flag[0] = 1'b0;                   // [RULE11]
                intr_pkg::VEC_SLOT1: d.slot_flag[1] = 1'b0;                   // [RULE11]
                intr_pkg::VEC_GRP0:  d.grp_flag[0]  = 1'b0;                   // [RULE4]
                intr_pkg::VEC_GRP1:  d.grp_flag[1]  = 1'b0;                   // [RULE4]
                intr_pkg::VEC_TMR0:  d.tmr_flag[0]  = 1'b0;                   // [RULE8]
                intr_pkg::VEC_TMR1:  d.tmr_flag[1]  = 1'b0;                   // [RULE8]
                intr_pkg::VEC_TB:    d.tb_flag      = 1'b0;                   // [RULE5]
                intr_pkg::VEC_SER:   d.ser_flag     = 1'b0;                   // [RULE12]
            endcase
        end

        // hardware sets last so a same-cycle clear never swallows an event
        d.tb_flag   = d.tb_flag   | tb_ovf;                                   // [RULE5] [RULE22]
        d.tmr_flag  = d.tmr_flag  | tmr_ovf_in;                               // [RULE8] [RULE22]
        d.slot_flag = d.slot_flag | slot_ovf_in;                              // [RULE11] [RULE22]
        d.ser_flag  = d.ser_flag  | ser_byte_in;                              // [RULE12] [RULE22]
        d.tkt_flag  = d.tkt_flag  | tkt_ovf_in;                               // [RULE22]
        d.ee_flag   = d.ee_flag   | ee_done_in;                               // [RULE9] [RULE22]
        d.grp_flag  = d.grp_flag  | grp_event;                                // [RULE2] [RULE22]
        // enables never touch flags, so a masked flag simply waits     [RULE15]

        // wake on any flag going low to high, enables play no part
        d.ans.wake = |({d.tb_flag, d.ser_flag, d.tmr_flag, d.grp_flag, d.slot_flag,
                        d.tkt_flag, d.ee_flag}
                     & ~{q.tb_flag, q.ser_flag, q.tmr_flag, q.grp_flag, q.slot_flag,
                         q.tkt_flag, q.ee_flag});                             // [RULE13]

        d.ans.global_en = d.global_en;

        // read data for the next cycle; unmapped offsets read zero
        if (reg_req_in.rd)
        begin
            unique case (reg_req_in.addr)
                intr_pkg::OFS_ENABLE:
                    d.rdata = {1'b0, q.grp_en, q.tmr_en, q.ser_en, q.tb_en, q.global_en};
                intr_pkg::OFS_FLAGS:
                    d.rdata = {q.slot_flag, q.grp_flag, q.tmr_flag, q.ser_flag, q.tb_flag};
                intr_pkg::OFS_SRC_EN:
                    d.rdata = {1'b0, q.slot_en, q.ee_en, q.tkt_en};
                intr_pkg::OFS_SRC_FLAGS:
                    d.rdata = {3'h0, q.ee_flag, q.tkt_flag};
                intr_pkg::OFS_TB_CTRL:
                    d.rdata = {2'h0, q.tb_sel, 4'h0};                         // [RULE7]
                intr_pkg::OFS_TB_CLKSEL:
                    d.rdata = {7'h00, q.tb_clk_sel};
                default:
                    d.rdata = '0;
            endcase
        end
    end

    // one register for all state; ce low freezes everything
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            q <= '0;
        else if (ce_in)
            q <= d;
    end

    assign reg_rdata_out = q.rdata;
    assign core_ans_out  = q.ans;
endmodule

// ---- verif/core_model.sv ----
// core_model: processor core on the vector side of the interrupt unit.
// assumes take_in is the unit's one-cycle vector call pulse.
`timescale 1ns/10ps
module core_model
(
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic take_in,
    input  wire logic slow_in,
    input  wire logic full_in,
    output logic      boundary_out = 1'b1,
    output logic      stack_full_out = 1'b0,
    output logic      ret_irq_out = 1'b0
);
    int unsigned left_q;

    // a call pushes only the pc; the routine saves its own working registers,
    // makes no nested calls and leaves by a return-from-interrupt
    always @(posedge core_clk_in)
    begin
        ret_irq_out <= 1'b0;
        boundary_out <= slow_in ? 1'($urandom) : 1'b1; // slow core misses boundaries
        stack_full_out <= full_in;
        if (sys_rst_in)
            left_q <= 0;
        else if (take_in)
            left_q <= slow_in ? 5 + $urandom % 16 : 3;
        else if (left_q == 1)
        begin
            left_q <= 0;
            ret_irq_out <= 1'b1;
        end
        else if (left_q != 0)
            left_q <= left_q - 1;
    end
endmodule

// ---- verif/mcu_interrupt_unit_checker.sv ----
// mcu_interrupt_unit_checker: timing relations at the unit's ports.
// assumes the clock enable is held high, so every edge counts.
`timescale 1ns/10ps
module mcu_interrupt_unit_checker
(
    input wire logic                   core_clk_in,
    input wire logic                   sys_rst_in,
    input wire intr_pkg::reg_req_type  reg_req_in,
    input wire logic [7:0]             reg_rdata_out,
    input wire logic                   boundary_in,
    input wire logic                   stack_full_in,
    input wire logic                   ret_irq_in,
    input wire intr_pkg::core_ans_type core_ans_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_take_gie: assert property (core_ans_out.take |-> $past(core_ans_out.global_en))
        else $error("vector taken while global enable was low");
    chk_take_stack: assert property (core_ans_out.take |-> !$past(stack_full_in))
        else $error("vector taken with a full stack");
    chk_take_bound: assert property (core_ans_out.take |-> $past(boundary_in))
        else $error("vector taken off a boundary");
    chk_take_clears: assert property (core_ans_out.take |-> !core_ans_out.global_en)
        else $error("global enable still set after a call");
    chk_take_single: assert property (core_ans_out.take |=> !core_ans_out.take)
        else $error("second call without a new global enable");
    chk_return_sets: assert property (ret_irq_in |=>
        core_ans_out.global_en || core_ans_out.take)
        else $error("return did not restore global enable");
    chk_gie_cause: assert property ($rose(core_ans_out.global_en) |-> $past(ret_irq_in)
        || ($past(reg_req_in.wr) && $past(reg_req_in.addr) == intr_pkg::OFS_ENABLE))
        else $error("global enable rose without return or write");
    chk_vec_hold: assert property (!core_ans_out.take |-> $stable(core_ans_out.vec))
        else $error("vector number moved without a call");
    chk_period_read: assert property (reg_req_in.wr
        && reg_req_in.addr == intr_pkg::OFS_TB_CTRL
        ##2 reg_req_in.rd && reg_req_in.addr == intr_pkg::OFS_TB_CTRL
        |=> reg_rdata_out == ($past(reg_req_in.wdata, 3) & 8'h30))
        else $error("period select read back wrong");
    chk_unmapped: assert property ($past(reg_req_in.rd) &&
        $past(reg_req_in.addr) > intr_pkg::OFS_TB_CLKSEL |-> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

// ---- verif/mcu_interrupt_unit_tb.sv ----
// mcu_interrupt_unit_tb: self-checking bench for the interrupt unit with a
// core model on the vector side.
// assumes the clock enable stays high throughout the run.
`timescale 1ns/10ps
module mcu_interrupt_unit_tb;
    logic                   clk;
    logic                   rst;
    intr_pkg::reg_req_type  req;
    logic [7:0]             rdata;
    intr_pkg::core_ans_type ans;
    logic [9:0]             ev;
    logic                   tick, lirc_on, slow, full_cmd, boundary, stack_full, ret_irq;
    logic [2:0]             last_vec;
    logic [31:0]            rnd;
    int                     cyc, take_cnt, wake_cnt, wake_at, n_fail, samples_checked;
    int                     w, t0, t1;

    mcu_interrupt_unit dut_u (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1),
        .reg_req_in(req), .reg_rdata_out(rdata), .boundary_in(boundary),
        .stack_full_in(stack_full), .ret_irq_in(ret_irq), .core_ans_out(ans),
        .lirc_tick_in(tick), .tmr_ovf_in(ev[9:8]), .slot_ovf_in(ev[7:6]),
        .tkt_ovf_in(ev[5:2]), .ee_done_in(ev[1]), .ser_byte_in(ev[0]));
    core_model core_u (.core_clk_in(clk), .sys_rst_in(rst), .take_in(ans.take),
        .slow_in(slow), .full_in(full_cmd), .boundary_out(boundary),
        .stack_full_out(stack_full), .ret_irq_out(ret_irq));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // event log: calls, wake pulses, and a slow tick every fourth cycle
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        tick <= lirc_on && cyc % 4 == 3;
        if (ans.take)
        begin
            take_cnt <= take_cnt + 1;
            last_vec <= ans.vec;
        end
        if (ans.wake)
        begin
            wake_cnt <= wake_cnt + 1;
            wake_at <= cyc;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 check(rdata, exp);
    endtask

    task automatic pulse(input logic [9:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
    endtask

    task automatic wait_take(input logic [2:0] v);
        int n;
        n = take_cnt;
        for (int i = 0; i < 300 && take_cnt == n; i++) @(posedge clk);
        #1 check({take_cnt != n, last_vec}, {1'b1, v});
    endtask

    // spacing of the last two of three wake pulses gives the period;
    // the first is skipped because the select changed mid-count
    task automatic tb_period(input logic [1:0] code, input int per);
        rnd = $urandom;
        wr(intr_pkg::OFS_TB_CTRL, {rnd[7:6], code, rnd[3:0]});
        for (int k = 0; k < 3; k++)
        begin
            w = wake_cnt;
            for (int i = 0; i < 40000 && wake_cnt == w; i++) @(posedge clk);
            #1 t1 = t0;
            t0 = wake_at;
            wr(intr_pkg::OFS_FLAGS, 8'h00);
        end
        check(t0 - t1, per);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #(40 * 90000);
        n_fail++;
        final_report;
    end

    initial
    begin
        rst = 1'b1;
        {req, ev, lirc_on, slow, full_cmd} = '0;
        {n_fail, samples_checked, t0} = '0;
        rnd = $urandom(29052);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rchk(a[3:0], 8'h00);
        wr(intr_pkg::OFS_TB_CLKSEL, 8'h01); // no slow ticks yet, so time base is still
        for (int i = 0; i < 12; i++)
        begin
            rnd = $urandom;
            wr(intr_pkg::OFS_TB_CTRL, rnd[7:0]);
            rchk(intr_pkg::OFS_TB_CTRL, rnd[7:0] & 8'h30);
        end
        w = wake_cnt;
        pulse(10'h181); // timer 0, slot 1, serial
        rchk(intr_pkg::OFS_FLAGS, 8'h86);
        check(wake_cnt - w, 1);
        wr(intr_pkg::OFS_SRC_EN, 8'h40);
        wr(intr_pkg::OFS_ENABLE, 8'h0C);
        repeat (20) @(posedge clk);
        check(take_cnt, 0);
        wr(intr_pkg::OFS_ENABLE, 8'h00);
        rchk(intr_pkg::OFS_FLAGS, 8'h86);
        full_cmd <= 1'b1;
        slow <= 1'b1;
        wr(intr_pkg::OFS_ENABLE, 8'h0D);
        repeat (20) @(posedge clk);
        check(take_cnt, 0);
        full_cmd <= 1'b0;
        wait_take(3'h1);
        wait_take(3'h4);
        wait_take(3'h7);
        rchk(intr_pkg::OFS_FLAGS, 8'h00);
        // grouped requests from a touch timer and the eeprom
        wr(intr_pkg::OFS_SRC_EN, 8'h14);
        wr(intr_pkg::OFS_ENABLE, 8'h61);
        pulse(10'h010);
        wait_take(3'h3);
        rchk(intr_pkg::OFS_SRC_FLAGS, 8'h04);
        wr(intr_pkg::OFS_SRC_FLAGS, 8'h00);
        pulse(10'h002);
        wait_take(3'h2);
        rchk(intr_pkg::OFS_SRC_FLAGS, 8'h10);
        wr(intr_pkg::OFS_SRC_FLAGS, 8'h00);
        rchk(intr_pkg::OFS_FLAGS, 8'h00);
        // a clear landing with a new event must not lose the event
        wr(intr_pkg::OFS_ENABLE, 8'h00);
        @(posedge clk);
        req <= '{addr: intr_pkg::OFS_FLAGS, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        ev <= 10'h200;
        @(posedge clk);
        {req, ev} <= '0;
        rchk(intr_pkg::OFS_FLAGS, 8'h08);
        w = wake_cnt;
        pulse(10'h200);
        repeat (3) @(posedge clk);
        #1 check(wake_cnt - w, 0);
        slow <= 1'b0;
        wr(intr_pkg::OFS_TB_CLKSEL, 8'h00);
        for (int c = 0; c < 4; c++) tb_period(c[1:0], 1024 << c);
        lirc_on <= 1'b1;
        wr(intr_pkg::OFS_TB_CLKSEL, 8'h01);
        tb_period(2'b00, 4096);
        lirc_on <= 1'b0;
        wr(intr_pkg::OFS_FLAGS, 8'h01);
        wr(intr_pkg::OFS_ENABLE, 8'h03);
        wait_take(3'h6);
        final_report;
    end
endmodule

bind mcu_interrupt_unit mcu_interrupt_unit_checker chk_u (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .boundary_in(boundary_in), .stack_full_in(stack_full_in), .ret_irq_in(ret_irq_in),
    .core_ans_out(core_ans_out));
